//--- ref_clock_request_stop_control.sv
// Output control of a multi-output clock generator: control bytes 3..7 behind
// a byte-level register port, and request-driven stop/restart of six serial
// reference outputs. Assumes an upstream SMBus engine that delivers address,
// command and data bytes as one-cycle strobes synchronous to mclk, and that
// the running serial-reference and differential clocks arrive as mclk-synchronous
// levels/enables.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Byte 3 bit 7: stopped reference outputs driven (0) or undriven (1).
// - Byte 3 bit 6: CPU clocks driven or three-stated during power-down.
// - Byte 3 bit 5: reference clocks driven or three-stated during power-down.
// - Byte 3 bit 0: link clock drive strength, 0 high, 1 low.
// - Byte 4 bits 7..2 let request 0 stop reference outputs 5..0.
// - Byte 4 bit 1 enables the link clock; bit 0 reserved.
// - Byte 5 bits 7..2 let request 1 stop outputs 5..0; bits 1..0 reserved.
// - Byte 6 bit 6 enters test mode; bit 7 picks divided reference or three-state.
// - Byte 6 bit 5: reference clock drive strength, 0 low, 1 high.
// - Active-low requests stop only the outputs their select byte marks.
// - Request level counts only after holding over two differential clock rises.
// - Request pins are asynchronous and are synchronised before use.
// - Withdrawn request halts each selected output at its next rising edge.
// - Driven stop mode parks true leg high, complement low, normal current.
// - Undriven stop mode leaves both legs undriven at low level.
// - Assertion restarts all stopped outputs together, glitch free, within 2-6 periods.
// - Undriven stop mode drives true leg high quickly after assertion.
// - Port answers only slave addresses 11010010 and 11010011.
// - Command bit 7 selects byte access, bits 4..0 the offset; block starts at 0.
module ref_clock_request_stop_control
    import ref_clock_ctrl_pkg::*;
#(
    parameter logic [3:0] REVISION_CODE = 4'h2,  // Arbitrary value
    parameter logic [3:0] VENDOR_CODE   = 4'h5,  // Arbitrary value
    parameter logic [3:0] HW_STRAP_BITS = 4'h0   // Byte 6 bits 3..0, fixed in hardware
) (
    input  wire logic                   mclk,             // 50 MHz control clock
    input  wire logic                   rst_n,            // Async reset, active low
    input  wire logic                   smb_start,        // Pulse: address+command taken
    input  wire logic [7:0]             smb_addr,         // Slave address byte incl. R/W
    input  wire logic [7:0]             smb_cmd,          // Command code byte
    input  wire logic                   smb_wr,           // Pulse: data byte written
    input  wire logic [7:0]             smb_wdata,        // Write data byte
    input  wire logic                   smb_rd,           // Pulse: data byte requested
    input  wire logic                   smb_stop,         // Pulse: transaction over
    output logic                        smb_ack,          // Address/command accepted
    output logic [7:0]                  smb_rdata,        // Read data byte
    input  wire logic [1:0]             clock_request_n,  // Async request pins
    input  wire logic                   diff_clk_rise,    // Enable: output clock rising edge
    input  wire logic                   src_phase,        // Running reference clock level
    output logic [ref_clock_ctrl_pkg::NUM_SRC-1:0] src_true, // True leg level
    output logic [ref_clock_ctrl_pkg::NUM_SRC-1:0] src_comp, // Complement leg level
    output logic [ref_clock_ctrl_pkg::NUM_SRC-1:0] src_oe,   // Leg drive enable
    output logic                        cpu_pd_tristate,  // CPU clocks undriven in power-down
    output logic                        src_pd_tristate,  // Ref clocks undriven in power-down
    output logic                        link_clk_enable,  // 66 MHz link clock on
    output logic                        link_clk_low_drv, // Link clock low drive
    output logic                        test_mode,        // Test clock mode entered
    output logic                        test_ref_div,     // Test: divided ref, else three-state
    output logic                        ref_high_drive    // Ref outputs high drive
);
    import ref_clock_ctrl_pkg::*;

    logic [7:0] stop_pd_q, stop_pd_d;
    logic [7:0] sel0_q, sel0_d;
    logic [7:0] sel1_q, sel1_d;
    logic [7:0] test_ref_q, test_ref_d;
    logic [4:0] ptr_q, ptr_d;
    logic       sess_q, sess_d;
    logic       block_q, block_d;
    logic       ack_q, ack_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] rd_mux;
    logic       addr_hit;

    // Read view of the byte map; unmapped offsets read zero
    always_comb begin
        unique case (ptr_q)
            OFS_STOP_PD:  rd_mux = stop_pd_q;
            OFS_REQ0_SEL: rd_mux = sel0_q;
            OFS_REQ1_SEL: rd_mux = sel1_q;
            OFS_TEST_REF: rd_mux = test_ref_q;
            OFS_IDENTITY: rd_mux = {REVISION_CODE, VENDOR_CODE};
            default:      rd_mux = 8'h00;
        endcase
    end

    // Address/command decode and byte writes; masks keep reserved bits fixed
    always_comb begin
        addr_hit   = (smb_addr[7:1] == SLAVE_ADDR[7:1]) && !smb_cmd[CMD_CHIP_HI]
                     && !smb_cmd[CMD_CHIP_LO];
        stop_pd_d  = stop_pd_q;
        sel0_d     = sel0_q;
        sel1_d     = sel1_q;
        test_ref_d = test_ref_q;
        ptr_d      = ptr_q;
        sess_d     = sess_q;
        block_d    = block_q;
        ack_d      = 1'b0;
        rdata_d    = rdata_q;
        if (smb_start) begin
            sess_d  = addr_hit;
            ack_d   = addr_hit;
            block_d = !smb_cmd[CMD_BYTE_MODE];
            ptr_d   = smb_cmd[CMD_BYTE_MODE] ? smb_cmd[CMD_OFS_HI:0] : 5'h00;
        end else if (smb_stop) begin
            sess_d = 1'b0;
        end else if (sess_q && smb_wr) begin
            unique case (ptr_q)
                OFS_STOP_PD:  stop_pd_d  = (stop_pd_q & ~WMASK_STOP_PD)
                                           | (smb_wdata & WMASK_STOP_PD);
                OFS_REQ0_SEL: sel0_d     = (sel0_q & ~WMASK_REQ0_SEL)
                                           | (smb_wdata & WMASK_REQ0_SEL);
                OFS_REQ1_SEL: sel1_d     = (sel1_q & ~WMASK_REQ1_SEL)
                                           | (smb_wdata & WMASK_REQ1_SEL);
                OFS_TEST_REF: test_ref_d = (test_ref_q & ~WMASK_TEST_REF)
                                           | (smb_wdata & WMASK_TEST_REF);
                default:      stop_pd_d  = stop_pd_q;
            endcase
            if (block_q) ptr_d = ptr_q + 5'h01;
        end else if (sess_q && smb_rd) begin
            rdata_d = rd_mux;
            if (block_q) ptr_d = ptr_q + 5'h01;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stop_pd_q  <= RST_STOP_PD;
            sel0_q     <= RST_REQ0_SEL;
            sel1_q     <= RST_REQ1_SEL;
            test_ref_q <= RST_TEST_REF_HI | {4'h0, HW_STRAP_BITS};
            ptr_q      <= 5'h00;
            sess_q     <= 1'b0;
            block_q    <= 1'b0;
            ack_q      <= 1'b0;
            rdata_q    <= 8'h00;
        end else begin
            stop_pd_q  <= stop_pd_d;
            sel0_q     <= sel0_d;
            sel1_q     <= sel1_d;
            test_ref_q <= test_ref_d;
            ptr_q      <= ptr_d;
            sess_q     <= sess_d;
            block_q    <= block_d;
            ack_q      <= ack_d;
            rdata_q    <= rdata_d;
        end
    end

    // Static control fields straight from the registers
    assign smb_ack          = ack_q;
    assign smb_rdata        = rdata_q;
    assign cpu_pd_tristate  = stop_pd_q[BIT_CPU_PD_TRI];
    assign src_pd_tristate  = stop_pd_q[BIT_SRC_PD_TRI];
    assign link_clk_low_drv = stop_pd_q[BIT_LINK_LOW_DRIVE];
    assign link_clk_enable  = sel0_q[BIT_LINK_ENABLE];
    assign test_mode        = test_ref_q[BIT_TEST_MODE];
    assign test_ref_div     = test_ref_q[BIT_TEST_SEL];
    assign ref_high_drive   = test_ref_q[BIT_REF_HIGH_DRIVE];

    // Request synchroniser and debounce; the first stage feeds only the second
    logic [1:0] req_s1_q, req_s2_q, req_samp_q, req_valid_n_q;
    logic [1:0] req_samp_d, req_valid_n_d;

    always_comb begin
        req_samp_d    = req_samp_q;
        req_valid_n_d = req_valid_n_q;
        if (diff_clk_rise) begin
            req_samp_d = req_s2_q;
            for (int r = 0; r < 2; r++) begin
                if (req_s2_q[r] == req_samp_q[r]) req_valid_n_d[r] = req_samp_q[r];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            req_s1_q      <= 2'h0;
            req_s2_q      <= 2'h0;
            req_samp_q    <= 2'h0;
            req_valid_n_q <= 2'h0;
        end else begin
            req_s1_q      <= clock_request_n;
            req_s2_q      <= req_s1_q;
            req_samp_q    <= req_samp_d;
            req_valid_n_q <= req_valid_n_d;
        end
    end

    // Stop/restart sequencing of the reference outputs
    logic                 src_phase_q;
    logic                 src_rise;
    logic [NUM_SRC-1:0]   stop_want, parked_q, parked_d, pending;
    logic [NUM_SRC-1:0]   true_d, comp_d, oe_d;
    restart_state_t       rs_q, rs_d;
    logic [2:0]           rs_cnt_q, rs_cnt_d;
    logic                 restart_go;
    logic                 tri_stop;

    assign src_rise   = src_phase && !src_phase_q;
    assign tri_stop   = stop_pd_q[BIT_STOP_TRISTATE];
    assign pending    = parked_q & ~stop_want;
    assign restart_go = (rs_q == RS_COUNT) && src_rise
                        && (rs_cnt_q == 3'(RESTART_SRC_PERIODS - 1));

    // One shared counter so that every waiting output resumes on the same edge
    always_comb begin
        rs_d     = rs_q;
        rs_cnt_d = rs_cnt_q;
        unique case (rs_q)
            RS_IDLE: begin
                rs_cnt_d = 3'h0;
                if (|pending) rs_d = RS_COUNT;
            end
            RS_COUNT: begin
                if (!(|pending) || restart_go) begin
                    rs_d     = RS_IDLE;
                    rs_cnt_d = 3'h0;
                end else if (src_rise) begin
                    rs_cnt_d = rs_cnt_q + 3'h1;
                end
            end
        endcase
    end

    // Per-output park decision and leg drive; parking on a rise keeps true high in driven stop mode
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        assign stop_want[i] = (req_valid_n_q[0] && sel0_q[SEL_LSB+i])
                              || (req_valid_n_q[1] && sel1_q[SEL_LSB+i]);

        always_comb begin
            parked_d[i] = parked_q[i];
            if (!parked_q[i] && stop_want[i] && src_rise) parked_d[i] = 1'b1;
            else if (parked_q[i] && !stop_want[i] && restart_go) parked_d[i] = 1'b0;
            if (!parked_d[i]) begin
                true_d[i] = src_phase;
                comp_d[i] = !src_phase;
                oe_d[i]   = 1'b1;
            end else if (!tri_stop || !stop_want[i]) begin
                true_d[i] = 1'b1;
                comp_d[i] = 1'b0;
                oe_d[i]   = 1'b1;
            end else begin
                true_d[i] = 1'b0;
                comp_d[i] = 1'b0;
                oe_d[i]   = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            src_phase_q <= 1'b0;
            parked_q    <= '0;
            rs_q        <= RS_IDLE;
            rs_cnt_q    <= 3'h0;
            src_true    <= '0;
            src_comp    <= '1;
            src_oe      <= '1;
        end else begin
            src_phase_q <= src_phase;
            parked_q    <= parked_d;
            rs_q        <= rs_d;
            rs_cnt_q    <= rs_cnt_d;
            src_true    <= true_d;
            src_comp    <= comp_d;
            src_oe      <= oe_d;
        end
    end

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_good_start;
        smb_start && addr_hit;
    endsequence
    sequence s_block_start;
        s_good_start ##0 !smb_cmd[CMD_BYTE_MODE];
    endsequence

    AST_ADDR_FILTER: assert property (smb_start && !addr_hit |=> !smb_ack)
        else $error("foreign address acknowledged");
    AST_BLOCK_PTR: assert property (s_block_start |=> ptr_q == 5'h00 && smb_ack)
        else $error("block access not at offset zero");
    AST_IDENTITY: assert property (sess_q && smb_rd && !smb_start && !smb_stop && !smb_wr
        && ptr_q == OFS_IDENTITY |=> smb_rdata == {REVISION_CODE, VENDOR_CODE})
        else $error("identity byte wrong");
    // Reserved bits of every control byte must never move from power-up
    AST_RESERVED: assert property (sel1_q[1:0] == 2'b00 && stop_pd_q[4:1] == 4'h7
        && sel0_q[0] && test_ref_q[4:0] == {1'b1, HW_STRAP_BITS})
        else $error("reserved bit changed");
    AST_DEBOUNCE: assert property ($changed(req_valid_n_q)
        |-> $past(diff_clk_rise) && $past(req_s2_q) == $past(req_samp_q))
        else $error("request level taken without two stable samples");
    AST_PARK_CAUSE: assert property ($rose(parked_q[0])
        |-> $past(stop_want[0]) && $past(src_rise))
        else $error("output parked without request or edge");
    AST_PARK_DRIVEN: assert property (parked_q[0] && stop_want[0] && !tri_stop
        |=> src_true[0] && !src_comp[0] && src_oe[0])
        else $error("driven park level wrong");
    AST_PARK_TRI: assert property (parked_q[0] && stop_want[0] && tri_stop
        |=> !src_true[0] && !src_comp[0] && !src_oe[0])
        else $error("undriven park level wrong");
    AST_RESTART: assert property ($fell(parked_q[0])
        |-> $past(src_rise) && $past(rs_cnt_q) == 3'(RESTART_SRC_PERIODS - 1))
        else $error("restart not on the counted edge");
    AST_TRI_WAKE: assert property (parked_q[0] && tri_stop && $fell(stop_want[0])
        |=> src_oe[0] && src_true[0])
        else $error("true leg not driven high after assertion");

endmodule : ref_clock_request_stop_control

`default_nettype wire

//--- ref_clock_ctrl_pkg.sv
// Constants for the reference-clock request-stop and output control block.
// Assumes a single 50 MHz control clock; all times are turned into cycles here.
package ref_clock_ctrl_pkg;

    // Register port decode
    localparam logic [7:0] SLAVE_ADDR      = 8'hD2;
    localparam int         CMD_BYTE_MODE   = 7;
    localparam int         CMD_CHIP_HI     = 6;
    localparam int         CMD_CHIP_LO     = 5;
    localparam int         CMD_OFS_HI      = 4;

    // Register offsets
    localparam logic [4:0] OFS_STOP_PD     = 5'h03;
    localparam logic [4:0] OFS_REQ0_SEL    = 5'h04;
    localparam logic [4:0] OFS_REQ1_SEL    = 5'h05;
    localparam logic [4:0] OFS_TEST_REF    = 5'h06;
    localparam logic [4:0] OFS_IDENTITY    = 5'h07;

    // Power-up values and writable-bit masks (reserved bits hold power-up value)
    localparam logic [7:0] RST_STOP_PD     = 8'hAF;
    localparam logic [7:0] RST_REQ0_SEL    = 8'h03;
    localparam logic [7:0] RST_REQ1_SEL    = 8'h00;
    localparam logic [7:0] RST_TEST_REF_HI = 8'h10;
    localparam logic [7:0] WMASK_STOP_PD   = 8'hE1;
    localparam logic [7:0] WMASK_REQ0_SEL  = 8'hFE;
    localparam logic [7:0] WMASK_REQ1_SEL  = 8'hFC;
    localparam logic [7:0] WMASK_TEST_REF  = 8'hE0;

    // Field positions
    localparam int BIT_STOP_TRISTATE  = 7;
    localparam int BIT_CPU_PD_TRI     = 6;
    localparam int BIT_SRC_PD_TRI     = 5;
    localparam int BIT_LINK_LOW_DRIVE = 0;
    localparam int BIT_LINK_ENABLE    = 1;
    localparam int SEL_LSB            = 2;
    localparam int BIT_TEST_SEL       = 7;
    localparam int BIT_TEST_MODE      = 6;
    localparam int BIT_REF_HIGH_DRIVE = 5;

    // Timing
    localparam int NUM_SRC            = 6;
    localparam int RESTART_SRC_PERIODS = 2;
    localparam int CLK_PERIOD_NS      = 20;
    localparam int TRI_DRIVE_NS       = 10;
    localparam int TRI_DRIVE_CYCLES   = (TRI_DRIVE_NS / CLK_PERIOD_NS < 1) ? 1
                                        : TRI_DRIVE_NS / CLK_PERIOD_NS;

    typedef enum logic [0:0] {
        RS_IDLE  = 1'b0,
        RS_COUNT = 1'b1
    } restart_state_t;

endpackage : ref_clock_ctrl_pkg

//--- ref_clock_requester.sv
// Behavioural far side of the request-stop block: the requesting device and
// the running differential and serial-reference clock sources.
// Assumes the bench commands the wanted clock level per request input.
`timescale 1ns/1ps
`default_nettype none

module ref_clock_requester (
    input  wire logic       mclk,            // Control clock
    input  wire logic [1:0] req_want,        // 1 = clocks wanted on that input
    output logic [1:0]      clock_request_n, // Request pins, active low
    output logic            diff_clk_rise,   // One-cycle enable per output rise
    output logic            src_phase        // Running reference level
);
    logic [1:0] div_q;

    initial begin
        div_q           = 2'h0;
        diff_clk_rise   = 1'b0;
        src_phase       = 1'b0;
        clock_request_n = 2'h0;
    end

    // Both clocks at a quarter of mclk, so one output period is four cycles
    always @(posedge mclk) begin
        div_q         <= #2 div_q + 2'h1;
        diff_clk_rise <= #2 (div_q == 2'h3);
        src_phase     <= #2 div_q[1];
    end

    // Pins move 7 ns after the command, tied to no clock edge; the bench holds
    // each level far longer than two output rises
    always @(req_want) begin
        clock_request_n <= #7 ~req_want;
    end
endmodule : ref_clock_requester

`default_nettype wire

//--- tb_ref_clock_request_stop_control.sv
// Self-checking bench for the request-stop block: register port by byte
// strobes, then stop and restart of selected outputs in both drive modes.
// Assumes the requester model supplies pins and running clocks.
`timescale 1ns/1ps
`default_nettype none

module tb_ref_clock_request_stop_control;
    import ref_clock_ctrl_pkg::*;

    logic mclk, rst_n, smb_start, smb_wr, smb_rd, smb_stop, smb_ack, diff_clk_rise, src_phase;
    logic link_clk_enable, link_clk_low_drv, test_mode, test_ref_div, ref_high_drive;
    logic cpu_pd_tristate, src_pd_tristate;
    logic [7:0] smb_addr, smb_cmd, smb_wdata, smb_rdata;
    logic [1:0] clock_request_n, req_want;
    logic [NUM_SRC-1:0] src_true, src_comp, src_oe;
    int num_errors, checks, n;
    logic [7:0] rst_val [3:6];
    logic [7:0] wmask   [3:6];
    logic [7:0] exp_b   [0:7];

    ref_clock_request_stop_control #(
        .REVISION_CODE (4'h3), // Arbitrary value
        .VENDOR_CODE   (4'h6), // Arbitrary value
        .HW_STRAP_BITS (4'hA)
    ) ref_clock_request_stop_control_i (
        .mclk(mclk), .rst_n(rst_n), .smb_start(smb_start), .smb_addr(smb_addr),
        .smb_cmd(smb_cmd), .smb_wr(smb_wr), .smb_wdata(smb_wdata), .smb_rd(smb_rd),
        .smb_stop(smb_stop), .smb_ack(smb_ack), .smb_rdata(smb_rdata),
        .clock_request_n(clock_request_n), .diff_clk_rise(diff_clk_rise),
        .src_phase(src_phase), .src_true(src_true), .src_comp(src_comp), .src_oe(src_oe),
        .cpu_pd_tristate(cpu_pd_tristate), .src_pd_tristate(src_pd_tristate),
        .link_clk_enable(link_clk_enable), .link_clk_low_drv(link_clk_low_drv),
        .test_mode(test_mode), .test_ref_div(test_ref_div), .ref_high_drive(ref_high_drive));

    ref_clock_requester ref_clock_requester_i (
        .mclk(mclk), .req_want(req_want), .clock_request_n(clock_request_n),
        .diff_clk_rise(diff_clk_rise), .src_phase(src_phase));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic report_and_stop();
        if (num_errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Strobes rise 2 ns after an edge and drop after the taking edge
    task automatic pulse_start(input logic [7:0] addr, input logic [7:0] cmd,
                               input logic exp_ack);
        @(posedge mclk) #2;
        smb_start = 1'b1; smb_addr = addr; smb_cmd = cmd;
        @(posedge mclk) #2;
        smb_start = 1'b0;
        check("smb_ack", {7'h00, smb_ack}, {7'h00, exp_ack});
    endtask : pulse_start

    task automatic pulse_wr(input logic [7:0] d);
        @(posedge mclk) #2;
        smb_wr = 1'b1; smb_wdata = d;
        @(posedge mclk) #2;
        smb_wr = 1'b0;
    endtask : pulse_wr

    task automatic pulse_rd(input logic [7:0] exp);
        @(posedge mclk) #2;
        smb_rd = 1'b1;
        @(posedge mclk) #2;
        smb_rd = 1'b0;
        check("smb_rdata", smb_rdata, exp);
    endtask : pulse_rd

    task automatic pulse_stop();
        @(posedge mclk) #2;
        smb_stop = 1'b1;
        @(posedge mclk) #2;
        smb_stop = 1'b0;
    endtask : pulse_stop

    task automatic reg_write(input logic [4:0] ofs, input logic [7:0] d);
        pulse_start(SLAVE_ADDR, {3'b100, ofs}, 1'b1);
        pulse_wr(d);
        pulse_stop();
    endtask : reg_write

    task automatic reg_read(input logic [4:0] ofs, input logic [7:0] exp);
        pulse_start(SLAVE_ADDR | 8'h01, {3'b100, ofs}, 1'b1);
        pulse_rd(exp);
        pulse_stop();
    endtask : reg_read

    // Write every control byte, then read all back in byte mode
    task automatic write_all_check(input logic [7:0] d);
        for (int k = 3; k <= 7; k++) reg_write(k[4:0], d);
        for (int k = 3; k <= 6; k++) exp_b[k] = (d & wmask[k]) | (rst_val[k] & ~wmask[k]);
        for (int k = 3; k <= 7; k++) reg_read(k[4:0], exp_b[k]);
    endtask : write_all_check

    // Bounded wait for one leg signal (0 true, 1 enable) to reach a level
    task automatic wait_leg(input int sel, input int i, input logic v, output int cnt);
        cnt = 0;
        while (((sel == 0) ? src_true[i] : src_oe[i]) !== v) begin
            @(posedge mclk) #2;
            cnt++;
            if (cnt > 60) begin
                check("wait_leg timeout", 8'h01, 8'h00);
                report_and_stop();
            end
        end
    endtask : wait_leg

    initial begin
        rst_n = 1'b0; smb_start = 1'b0; smb_wr = 1'b0; smb_rd = 1'b0; smb_stop = 1'b0;
        smb_addr = 8'h00; smb_cmd = 8'h00; smb_wdata = 8'h00; req_want = 2'h3;
        num_errors = 0; checks = 0;
        rst_val[3] = RST_STOP_PD; rst_val[4] = RST_REQ0_SEL; rst_val[5] = RST_REQ1_SEL;
        rst_val[6] = RST_TEST_REF_HI | 8'h0A;
        wmask[3] = WMASK_STOP_PD; wmask[4] = WMASK_REQ0_SEL;
        wmask[5] = WMASK_REQ1_SEL; wmask[6] = WMASK_TEST_REF;
        exp_b[0] = 8'h00; exp_b[1] = 8'h00; exp_b[2] = 8'h00; exp_b[7] = 8'h36;
        repeat (6) @(posedge mclk);
        #2 rst_n = 1'b1;
        // Power-up values, identity byte included
        for (int k = 3; k <= 6; k++) reg_read(k[4:0], rst_val[k]);
        reg_read(OFS_IDENTITY, exp_b[7]);
        // All writable bits set, then all cleared; level outputs follow the bits
        write_all_check(8'hFF);
        check("flags set", {1'b0, cpu_pd_tristate, src_pd_tristate, link_clk_enable,
              link_clk_low_drv, test_mode, test_ref_div, ref_high_drive}, 8'h7F);
        write_all_check(8'h00);
        check("flags clear", {1'b0, cpu_pd_tristate, src_pd_tristate, link_clk_enable,
              link_clk_low_drv, test_mode, test_ref_div, ref_high_drive}, 8'h00);
        // Foreign address and foreign chip select are refused, data ignored
        pulse_start(8'hD4, 8'h84, 1'b0);
        pulse_wr(8'hFF);
        pulse_stop();
        pulse_start(SLAVE_ADDR, 8'hA4, 1'b0);
        pulse_wr(8'hFF);
        pulse_stop();
        reg_read(OFS_REQ0_SEL, exp_b[4]);
        reg_read(5'h10, 8'h00);
        // Block write from offset 0, block read back all eight bytes
        pulse_start(SLAVE_ADDR, 8'h00, 1'b1);
        for (int k = 0; k < 7; k++) pulse_wr((k == 4) ? 8'h07 : (k == 5) ? 8'h80 : 8'h00);
        pulse_stop();
        exp_b[3] = 8'h0E; exp_b[4] = 8'h07; exp_b[5] = 8'h80; exp_b[6] = rst_val[6];
        pulse_start(SLAVE_ADDR | 8'h01, 8'h00, 1'b1);
        for (int k = 0; k < 8; k++) pulse_rd(exp_b[k]);
        pulse_stop();
        // Request 0 owns output 0, request 1 owns output 5; output 3 is free
        for (int m = 0; m < 2; m++) begin
            reg_write(OFS_STOP_PD, m ? 8'h80 : 8'h00);
            for (int r = 0; r < 2; r++) begin
                automatic int i = r ? 5 : 0;
                automatic int tog = 0;
                automatic logic prev3 = 1'b0;
                req_want[r] = 1'b0;
                repeat (40) @(posedge mclk);
                #2;
                prev3 = src_true[3];
                for (int c = 0; c < 8; c++) begin
                    check("parked legs", {5'h00, src_true[i], src_comp[i], src_oe[i]},
                          m ? 8'h00 : 8'h05);
                    // Unselected output 3 must keep toggling with the reference
                    if (src_true[3] !== prev3) tog++;
                    prev3 = src_true[3];
                    @(posedge mclk) #2;
                end
                check("free output runs", {7'h00, tog >= 3}, 8'h01);
                req_want[r] = 1'b1;
                if (m) begin
                    wait_leg(1, i, 1'b1, n);
                    check("wake true leg", {7'h00, src_true[i]}, 8'h01);
                end
                wait_leg(0, i, 1'b0, n);
                check("restart bound", {7'h00, n <= 40}, 8'h01);
                check("resumed legs", {5'h00, src_true[i], src_comp[i], src_oe[i]},
                      8'h03);
            end
        end
        report_and_stop();
    end
endmodule : tb_ref_clock_request_stop_control

`default_nettype wire
